/* inc/cgis_pkg.sv */
// Operation
// - dac codes below zero-gain drop 1 dB each
// - dac codes above zero-gain add 1 dB each
// - top bits 10 select sidetone/buffer, bit2 read-only
// - sidetone field 111 mutes, else -3 dB steps
// - buffer gain 0, 6, 12, 24 dB
// - top bits 11 select read-only version id
// - input select routes one of four inputs
// - group reads cycle adc, dac, sidetone, id
// - adc and dac gain reset to 101010
// - all-ones dac code mutes dac path
package cgis_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [11:0] GAIN_GROUP_OFFSET = 12'h000;
    localparam logic [11:0] INPUT_ROUTING_OFFSET = 12'h004;
    localparam logic [11:0] DECODED_STATUS_OFFSET = 12'h008;

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int SUB_SEL_MSB = 7;
    localparam int SUB_SEL_LSB = 6;
    localparam int GAIN_MSB = 5;
    localparam int ST_MSB = 5;
    localparam int ST_LSB = 3;
    localparam int IB_MSB = 1;
    localparam int AIS_MSB = 2;
    localparam int AIS_LSB = 1;

    localparam logic [1:0] SUB_ADC = 2'h0;
    localparam logic [1:0] SUB_DAC = 2'h1;
    localparam logic [1:0] SUB_SIDETONE = 2'h2;
    localparam logic [1:0] SUB_ID = 2'h3;

    // ----------------------------------------
    // reset values and codes
    // ----------------------------------------
    localparam logic [5:0] GAIN_RESET = 6'h2a;
    localparam logic [5:0] GAIN_MUTE_CODE = 6'h3f;
    localparam logic [2:0] ST_RESET = 3'h7;
    localparam logic [2:0] ST_MUTE_CODE = 3'h7;
    localparam logic [1:0] IB_RESET = 2'h0;
    localparam logic [7:0] ROUTING_RESET = 8'h00;
    // arbitrary value, not tied to any real part
    localparam logic [5:0] CHIP_VERSION_ID = 6'h05;

    typedef enum logic [1:0] {
        CGIS_IN_DIFF1 = 2'h0,
        CGIS_IN_MIC_SELF = 2'h1,
        CGIS_IN_MIC_EXT = 2'h2,
        CGIS_IN_DIFF2 = 2'h3
    } cgis_input_t;
endpackage

/* inc/cgis_dec_if.sv */
`timescale 1ns/100ps
interface cgis_dec_if;
    logic [5:0] dac_gain_code;
    logic [2:0] sidetone_gain_code;
    logic [1:0] input_buffer_gain;
    logic [1:0] analog_input_select;
    logic [7:0] dac_gain_db;
    logic dac_mute;
    logic [7:0] sidetone_db;
    logic sidetone_mute;
    logic [4:0] buffer_db;
    logic [3:0] route_onehot;

    modport ctl (
        output dac_gain_code, sidetone_gain_code, input_buffer_gain, analog_input_select,
        input dac_gain_db, dac_mute, sidetone_db, sidetone_mute, buffer_db, route_onehot
    );
    modport dec (
        input dac_gain_code, sidetone_gain_code, input_buffer_gain, analog_input_select,
        output dac_gain_db, dac_mute, sidetone_db, sidetone_mute, buffer_db, route_onehot
    );
endinterface

/* hdl/cgis_gain_dec.sv */
`timescale 1ns/100ps
module cgis_gain_dec
(
    cgis_dec_if.dec d
);
    import cgis_pkg::*;

    // ----------------------------------------
    // gain decode, dac and sidetone dB signed in two's complement, buffer dB unsigned
    // ----------------------------------------
    // code minus 42 gives -42..+21 dB, one dB per step
    assign d.dac_gain_db = {2'h0, d.dac_gain_code} - {2'h0, GAIN_RESET};
    assign d.dac_mute = (d.dac_gain_code == GAIN_MUTE_CODE);

    // -3 dB minus 3 dB per code step; mute code overrides
    wire [7:0] st_step = {5'h00, d.sidetone_gain_code} * 8'h03;
    assign d.sidetone_db = 8'hfd - st_step;
    assign d.sidetone_mute = (d.sidetone_gain_code == ST_MUTE_CODE);

    assign d.buffer_db = (d.input_buffer_gain == 2'h3) ? 5'h18 :
                         {1'b0, d.input_buffer_gain, 2'h0} +
                         {2'h0, d.input_buffer_gain, 1'b0};

    wire [3:0] route_base = 4'h1;
    assign d.route_onehot = route_base << d.analog_input_select;
endmodule

/* hdl/cgis_regs.sv */
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module cgis_regs
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [5:0] adc_gain_code,
    output logic [7:0] dac_gain_db,
    output logic dac_mute,
    output logic [7:0] sidetone_db,
    output logic sidetone_mute,
    output logic [4:0] buffer_db,
    output cgis_pkg::cgis_input_t analog_input_select,
    output logic [3:0] route_onehot
);
    import cgis_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [5:0] adc_gain_reg;
    logic [5:0] dac_gain_reg;
    logic [2:0] st_gain_reg;
    logic [1:0] ib_gain_reg;
    logic [7:0] routing_reg;
    logic [1:0] rd_ptr_reg;
    logic [1:0] rd_ptr_next;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [7:0] dac_db_reg;
    logic dac_mute_reg;
    logic [7:0] st_db_reg;
    logic st_mute_reg;
    logic [4:0] buf_db_reg;
    logic [3:0] route_reg;

    cgis_dec_if dif();

    cgis_gain_dec u_dec (
        .d(dif)
    );

    assign dif.dac_gain_code = dac_gain_reg;
    assign dif.sidetone_gain_code = st_gain_reg;
    assign dif.input_buffer_gain = ib_gain_reg;
    assign dif.analog_input_select = routing_reg[AIS_MSB:AIS_LSB];

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    // zero wait: pready is set in setup, so the access lasts one cycle
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_reg;
    wire hit_gain = (paddr == GAIN_GROUP_OFFSET);
    wire hit_route = (paddr == INPUT_ROUTING_OFFSET);
    wire hit_stat = (paddr == DECODED_STATUS_OFFSET);
    wire mapped = hit_gain | hit_route | hit_stat;
    wire wr_ok = access & pwrite & ~pslverr_reg & pstrb[0];
    wire [1:0] wr_sub = pwdata[SUB_SEL_MSB:SUB_SEL_LSB];
    wire wr_gain = wr_ok & hit_gain;
    wire wr_adc = wr_gain & (wr_sub == SUB_ADC);
    wire wr_dac = wr_gain & (wr_sub == SUB_DAC);
    wire wr_st = wr_gain & (wr_sub == SUB_SIDETONE);
    wire wr_route = wr_ok & hit_route;
    wire rd_gain = access & ~pwrite & hit_gain;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire [7:0] sub_adc = {SUB_ADC, adc_gain_reg};
    wire [7:0] sub_dac = {SUB_DAC, dac_gain_reg};
    // bit 2 is reserved and always reads zero
    wire [7:0] sub_st = {SUB_SIDETONE, st_gain_reg, 1'b0, ib_gain_reg};
    wire [7:0] sub_id = {SUB_ID, CHIP_VERSION_ID};
    wire [7:0] gain_rd = (rd_ptr_reg == SUB_ADC) ? sub_adc :
                         (rd_ptr_reg == SUB_DAC) ? sub_dac :
                         (rd_ptr_reg == SUB_SIDETONE) ? sub_st : sub_id;
    wire [31:0] stat_rd = {3'h0, buf_db_reg, 2'h0, st_mute_reg, dac_mute_reg,
                           route_reg, st_db_reg, dac_db_reg};
    wire [31:0] rd_word = hit_gain ? {24'h000000, gain_rd} :
                          hit_route ? {24'h000000, routing_reg} :
                          hit_stat ? stat_rd : 32'h00000000;

    // wraps back to the adc gain after the id
    assign rd_ptr_next = rd_gain ? rd_ptr_reg + 2'h1 : rd_ptr_reg;

    // ----------------------------------------
    // bus response
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~mapped;
        end
    end

    // captured in setup and held until the next setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h00000000;
        end
        else if (setup)
        begin
            prdata_reg <= pwrite ? 32'h00000000 : rd_word;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // writes with top bits 11 fall through: the id is read-only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_gain_reg <= GAIN_RESET;
        end
        else if (wr_adc)
        begin
            adc_gain_reg <= pwdata[GAIN_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_gain_reg <= GAIN_RESET;
        end
        else if (wr_dac)
        begin
            dac_gain_reg <= pwdata[GAIN_MSB:0];
        end
    end

    // bit 2 of the write data is dropped: reserved
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_gain_reg <= ST_RESET;
            ib_gain_reg <= IB_RESET;
        end
        else if (wr_st)
        begin
            st_gain_reg <= pwdata[ST_MSB:ST_LSB];
            ib_gain_reg <= pwdata[IB_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            routing_reg <= ROUTING_RESET;
        end
        else if (wr_route)
        begin
            routing_reg <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // read pointer
    // ----------------------------------------
    // only completed reads of the group move it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_ptr_reg <= SUB_ADC;
        end
        else
        begin
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // ----------------------------------------
    // registered decode outputs
    // ----------------------------------------
    // one cycle behind the control registers, keeps outputs glitch free
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_db_reg <= 8'h00;
            dac_mute_reg <= 1'b0;
            st_db_reg <= 8'h00;
            st_mute_reg <= 1'b1;
            buf_db_reg <= 5'h00;
            route_reg <= 4'h1;
        end
        else
        begin
            dac_db_reg <= dif.dac_gain_db;
            dac_mute_reg <= dif.dac_mute;
            st_db_reg <= dif.sidetone_db;
            st_mute_reg <= dif.sidetone_mute;
            buf_db_reg <= dif.buffer_db;
            route_reg <= dif.route_onehot;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign adc_gain_code = adc_gain_reg;
    assign dac_gain_db = dac_db_reg;
    assign dac_mute = dac_mute_reg;
    assign sidetone_db = st_db_reg;
    assign sidetone_mute = st_mute_reg;
    assign buffer_db = buf_db_reg;
    assign analog_input_select = cgis_input_t'(routing_reg[AIS_MSB:AIS_LSB]);
    assign route_onehot = route_reg;
endmodule

/* dv/cgis_regs_asserts.sv */
`timescale 1ns/100ps
module cgis_regs_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] adc_gain_code,
    input wire logic [7:0] dac_gain_db,
    input wire logic dac_mute,
    input wire logic sidetone_mute,
    input wire logic [7:0] sidetone_db,
    input wire logic [4:0] buffer_db,
    input wire logic [3:0] route_onehot
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite && pstrb[0];
    wire rd0 = acc && !pwrite && paddr == 12'h000;
    wire [5:0] wc = pwdata[5:0];
    wire [2:0] sc = pwdata[5:3];
    wire [1:0] ib = pwdata[1:0];
    wire [1:0] rs = pwdata[2:1];
    // ------
    // decoded outputs trail a write by two edges
    // ------
    sequence s_dac_wr;
        wr && paddr == 12'h000 && pwdata[7:6] == 2'h1;
    endsequence
    sequence s_st_wr;
        wr && paddr == 12'h000 && pwdata[7:6] == 2'h2;
    endsequence
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("ready missing");
    a_err_unmapped: assert property (acc && paddr > 12'h008 |-> pslverr)
        else $error("no error on unmapped");
    a_dac_db: assert property (s_dac_wr |-> ##2
        $past(wc, 2) == 6'h3f || dac_gain_db == {2'h0, $past(wc, 2)} - 8'h2a)
        else $error("dac gain wrong");
    a_dac_mute: assert property (s_dac_wr |-> ##2 dac_mute == ($past(wc, 2) == 6'h3f))
        else $error("dac mute wrong");
    a_st_gain: assert property (s_st_wr |-> ##2 sidetone_mute == ($past(sc, 2) == 3'h7) &&
        (sidetone_mute || sidetone_db == 8'hfd - 8'h03 * {5'h0, $past(sc, 2)}))
        else $error("sidetone wrong");
    a_buf_gain: assert property (s_st_wr |-> ##2
        buffer_db == ($past(ib, 2) == 2'h3 ? 5'h18 : 5'h06 * {3'h0, $past(ib, 2)}))
        else $error("buffer gain wrong");
    a_route_sel: assert property (wr && paddr == 12'h004 |-> ##2
        route_onehot == 4'h1 << $past(rs, 2))
        else $error("route wrong");
    a_st_reserved: assert property (rd0 && prdata[7:6] == 2'h2 |-> !prdata[2])
        else $error("reserved bit set");
    a_id_fixed: assert property (rd0 && prdata[7:6] == 2'h3 |->
        prdata[5:0] == cgis_pkg::CHIP_VERSION_ID)
        else $error("id wrong");
    a_reset_gain: assert property ($rose(presetn) |-> adc_gain_code == 6'h2a &&
        dac_gain_db == 8'h00 && sidetone_mute)
        else $error("reset values wrong");
endmodule
bind cgis_regs cgis_regs_asserts u_chk (.*);

/* dv/codec_gain_input_select_regs_tb.sv */
`timescale 1ns/100ps
module codec_gain_input_select_regs_tb;
    import cgis_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [3:0] pstrb = 4'hf, route_onehot;
    logic pready, pslverr, dac_mute, sidetone_mute, e;
    logic [5:0] adc_gain_code, c, g;
    logic [7:0] dac_gain_db, sidetone_db, lf = 8'h42;
    logic [4:0] buffer_db;
    logic [1:0] rp = 2'h0;
    cgis_input_t analog_input_select;
    int n_fail = 0, num_checks = 0, i;
    always #2 pclk = ~pclk;
    cgis_regs dut (.*);
    // ------
    // helpers
    // ------
    function logic [7:0] rnd(input logic [7:0] s);
        rnd = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // status word built field by field from the gain and routing rules
    function logic [31:0] stat_exp(input logic [5:0] dc, input logic [2:0] sc,
                                   input logic [1:0] ib, input logic [1:0] rs);
        stat_exp = {3'h0, ib == 2'h3 ? 5'h18 : 5'h06 * {3'h0, ib}, 2'h0, sc == 3'h7,
                    dc == 6'h3f, 4'h1 << rs, 8'hfd - 8'h03 * {5'h0, sc}, 8'(dc - 8'h2a)};
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // idle edge first, so a release never meets the next setup
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task grp(input logic [1:0] s, input logic [7:0] exp);
        do
        begin
            apb(1'b0, 12'h000, 32'h0);
            chk(rv[7:6], rp);
            rp++;
        end while (rp != s + 2'h1);
        chk(rv, {24'h0, exp});
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #40000;
        n_fail++;
        conclude;
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk({sidetone_mute, buffer_db, route_onehot}, {1'b1, 5'h00, 4'h1});
        grp(2'h0, 8'h2a);
        grp(2'h1, 8'h6a);
        grp(2'h2, 8'hb8);
        grp(2'h3, {2'h3, CHIP_VERSION_ID});
        for (i = 0; i < 16; i++)
        begin
            lf = rnd(lf);
            c = i == 4 ? 6'h37 : i < 4 ? 6'(i * 21) : lf[5:0];
            g = ~c;
            apb(1'b1, 12'h000, {24'h0, 2'h1, c});
            apb(1'b1, 12'h000, {24'h0, 2'h0, g});
            repeat (2) @(posedge pclk);
            chk(dac_mute, c == 6'h3f);
            if (c != 6'h3f)
                chk(dac_gain_db, 8'(c - 8'h2a));
            chk(adc_gain_code, g);
            grp(2'h0, {2'h0, g});
            grp(2'h1, {2'h1, c});
        end
        for (i = 0; i < 8; i++)
        begin
            apb(1'b1, 12'h000, {24'h0, 2'h2, 3'(i), 1'b1, 2'(i)});
            repeat (2) @(posedge pclk);
            chk(sidetone_mute, i == 7);
            if (i < 7)
                chk(sidetone_db, 8'hfd - 8'(3 * i));
            chk(buffer_db, i % 4 == 3 ? 5'h18 : 5'(6 * (i % 4)));
            grp(2'h2, {2'h2, 3'(i), 1'b0, 2'(i)});
        end
        apb(1'b1, 12'h000, 32'hfa);
        grp(2'h3, {2'h3, CHIP_VERSION_ID});
        grp(2'h0, {2'h0, g});
        grp(2'h2, 8'hbb);
        for (i = 0; i < 4; i++)
        begin
            lf = rnd(lf);
            apb(1'b1, 12'h004, {24'h0, lf[7:3], 2'(i), lf[0]});
            repeat (2) @(posedge pclk);
            chk(analog_input_select, i);
            chk(route_onehot, 4'h1 << i);
            apb(1'b0, 12'h004, 32'h0);
            chk(rv, {24'h0, lf[7:3], 2'(i), lf[0]});
        end
        apb(1'b1, 12'h00c, 32'h0);
        chk(e, 1'b1);
        pstrb <= 4'h0;
        apb(1'b1, 12'h004, 32'h0);
        pstrb <= 4'hf;
        repeat (2) @(posedge pclk);
        chk(route_onehot, 4'h8);
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, stat_exp(c, 3'h7, 2'h3, 2'h3));
        presetn <= 1'b0;
        @(posedge pclk);
        rp = 2'h0;
        presetn <= 1'b1;
        chk({analog_input_select, route_onehot}, {2'h0, 4'h1});
        grp(2'h0, 8'h2a);
        grp(2'h1, 8'h6a);
        conclude;
    end
endmodule
